/* File: verilog/sar_adc_host_interface.sv */
// Conversion control and host readout of an 18-bit SAR converter
//
// Overview of operation
// - A falling edge on conversion_start_n starts a conversion unless powered down or in reset.
// - A started conversion runs to its end; no restart, no power-down abort.
// - Conversion start ignores chip-select and read-enable.
// - Power-down waits for the running conversion; bus stays usable.
// - With configured power-down, the power_down_pin level is ignored.
// - Low-power mode drops core power once busy ends after each conversion.
// - Chip-select or read-enable high puts the data bus, serial data, serial clock and frame in high impedance.
// - coding_select picks twos complement or binary; 18-bit parallel is binary.
// - Reset rising edge aborts conversion and floats the data bus.
// - Reset falling edge clears state, output data and configuration.
// - Interface select 0, 1, 2 give 18, 16, 8 bit parallel.
// - Master parallel: bus driven continuously while selects are tied low.
// - Portion selects pick two words or three bytes of a result.
// - Interface select 3 gives the serial port on the data pins.
// - Serial sends 18 bits MSB first, one per clock pulse.
// - Configuration writes are taken only in serial mode.
// - Internal clocking makes serial clock and frame, each invertible.
// - Read-during: previous result sent during conversion, two clock periods.
// - Read-after: divider-set period, busy held until 18 bits sent.
// - External clock gated by chip-select; read while both selects low.
// - External read-during: overrun pulse if 18 bits not read by conversion end.
`timescale 1ns/10ps
module sar_adc_host_interface (
  input  wire logic        i_clk,
  input  wire logic        i_reset_n,
  input  wire logic        i_reset_pin,
  input  wire logic        i_conversion_start_n,
  input  wire logic        i_power_down_pin,
  input  wire logic        i_low_power_mode,
  input  wire logic        i_cfg_write,
  input  wire logic [1:0]  i_cfg_data,
  input  wire logic        i_cs_n,
  input  wire logic        i_rd_n,
  input  wire logic [1:0]  i_mode,
  input  wire logic        i_coding_select,
  input  wire logic        i_portion_select_lo,
  input  wire logic        i_portion_select_hi,
  input  wire logic        i_clock_source_select,
  input  wire logic        i_read_during_convert_sel,
  input  wire logic [1:0]  i_clock_divider_sel,
  input  wire logic        i_clock_invert,
  input  wire logic        i_frame_invert,
  input  wire logic        i_serial_clock,
  input  wire logic [17:0] i_sample_data,
  output logic             o_busy,
  output logic [17:0]      o_data_out,
  output logic [17:0]      o_data_oe,
  output logic             o_serial_data_out,
  output logic             o_serial_data_oe,
  output logic             o_serial_clock,
  output logic             o_serial_clock_oe,
  output logic             o_frame,
  output logic             o_frame_oe,
  output logic             o_read_overrun_flag,
  output logic             o_power_down_active,
  output logic             o_core_power_on,
  output logic [1:0]       o_config
);
  sar_adc_pkg::conv_state_type state_q;
  logic [7:0]  conv_cnt_q;
  logic        start_n_q;
  logic        rst_pin_q;
  logic        sclk_in_q;
  logic [1:0]  cfg_q;
  logic [17:0] out_q;
  logic [17:0] data_q;
  logic [17:0] sh_q;
  logic [4:0]  bit_cnt_q;
  logic        run_q;
  logic        sclk_q;
  logic [5:0]  div_q;
  logic        ovr_q;
  logic        start_fall;
  logic        rst_rise;
  logic        rst_fall;
  logic        pd_eff;
  logic        serial;
  logic        ext_clk;
  logic        enabled;
  logic        conv_go;
  logic        conv_end;
  logic        pop;
  logic        load_sh;
  logic        tick;
  logic        ser_done;
  logic        ext_fall;
  logic [5:0]  half;

  result_fifo_if #(.WIDTH(sar_adc_pkg::RES_BITS)) rf ();

  // Result path decoupled from the host; drain stalls while the internal clock shifts
  result_fifo #(
    .WIDTH(sar_adc_pkg::RES_BITS),
    .DEPTH(sar_adc_pkg::FIFO_DEPTH)
  ) u_fifo (
    .i_clk    (i_clk),
    .i_reset_n(i_reset_n),
    .i_flush  (rst_fall),
    .f        (rf.fifo)
  );

  // Output coding; core result is straight binary
  function automatic logic [17:0] code_result(input logic [17:0] raw,
                                              input logic [1:0] mode,
                                              input logic       bin);
    if (mode == sar_adc_pkg::MODE_PAR18 || bin) begin
      code_result = raw;
    end else begin
      code_result = {~raw[17], raw[16:0]};
    end
  endfunction : code_result

  // Parallel bus word for width and portion selects
  function automatic logic [17:0] portion_word(input logic [17:0] c,
                                               input logic [1:0] mode,
                                               input logic       hi,
                                               input logic       lo);
    portion_word = 18'h00000;
    case (mode)
      sar_adc_pkg::MODE_PAR16: begin
        portion_word[15:0] = lo ? {c[1:0], 14'h0000} : c[17:2];
      end
      sar_adc_pkg::MODE_PAR8: begin
        case ({hi, lo})
          2'h0:    portion_word[7:0] = c[17:10];
          2'h1:    portion_word[7:0] = c[9:2];
          default: portion_word[7:0] = {c[1:0], 6'h00};
        endcase
      end
      default: portion_word = c;
    endcase
  endfunction : portion_word

  // Edge detection on synchronous pins
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      start_n_q <= 1'b1;
      rst_pin_q <= 1'b0;
      sclk_in_q <= 1'b0;
    end else begin
      start_n_q <= i_conversion_start_n;
      rst_pin_q <= i_reset_pin;
      sclk_in_q <= i_serial_clock;
    end
  end

  assign start_fall = start_n_q && !i_conversion_start_n;
  assign rst_rise   = !rst_pin_q && i_reset_pin;
  assign rst_fall   = rst_pin_q && !i_reset_pin;
  assign pd_eff     = cfg_q[sar_adc_pkg::CFG_USE_BIT] ? cfg_q[sar_adc_pkg::CFG_PD_BIT]
                                                      : i_power_down_pin;
  assign serial     = (i_mode == sar_adc_pkg::MODE_SERIAL);
  assign ext_clk    = i_clock_source_select;
  assign enabled    = !i_cs_n && !i_rd_n && !rst_pin_q && !i_reset_pin;
  // Selects play no part in starting a conversion
  assign conv_go    = (state_q == sar_adc_pkg::ST_IDLE) && start_fall && !pd_eff
                      && !i_reset_pin && !rst_pin_q;
  assign conv_end   = (state_q == sar_adc_pkg::ST_CONV)
                      && (conv_cnt_q == 8'(sar_adc_pkg::CONV_CYCLES - 1));

  // Conversion sequencer
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_q    <= sar_adc_pkg::ST_IDLE;
      conv_cnt_q <= 8'h00;
    end else if (rst_rise || rst_pin_q) begin
      state_q    <= sar_adc_pkg::ST_IDLE;
      conv_cnt_q <= 8'h00;
    end else begin
      case (state_q)
        sar_adc_pkg::ST_IDLE: begin
          conv_cnt_q <= 8'h00;
          if (conv_go) state_q <= sar_adc_pkg::ST_CONV;
        end
        sar_adc_pkg::ST_CONV: begin
          // Start edges and power-down have no effect here
          conv_cnt_q <= conv_cnt_q + 8'h01;
          if (conv_end) state_q <= sar_adc_pkg::ST_STORE;
        end
        sar_adc_pkg::ST_STORE: begin
          // Waits here while the FIFO is full
          if (rf.wr_ready) begin
            state_q <= (serial && !ext_clk && !i_read_during_convert_sel)
                       ? sar_adc_pkg::ST_SHIFT : sar_adc_pkg::ST_IDLE;
          end
        end
        sar_adc_pkg::ST_SHIFT: begin
          if (ser_done) state_q <= sar_adc_pkg::ST_IDLE;
        end
        default: state_q <= sar_adc_pkg::ST_IDLE;
      endcase
    end
  end

  assign rf.wr_valid = (state_q == sar_adc_pkg::ST_STORE);
  assign rf.wr_data  = i_sample_data;
  assign rf.rd_ready = !run_q;
  assign pop         = rf.rd_valid && rf.rd_ready;
  assign o_busy      = (state_q != sar_adc_pkg::ST_IDLE);

  // Configuration bits, cleared by the reset pin
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cfg_q <= sar_adc_pkg::CFG_RESET;
    end else if (rst_fall) begin
      cfg_q <= sar_adc_pkg::CFG_RESET;
    end else if (i_cfg_write && serial) begin
      cfg_q <= i_cfg_data;
    end
  end

  assign o_config = cfg_q;

  // Power state; pending conversion always finishes first
  assign o_power_down_active = pd_eff && (state_q == sar_adc_pkg::ST_IDLE);
  assign o_core_power_on     = !o_power_down_active
                               && (!i_low_power_mode || state_q != sar_adc_pkg::ST_IDLE);

  // Held result and parallel data register
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      out_q  <= sar_adc_pkg::DATA_RESET;
      data_q <= sar_adc_pkg::DATA_RESET;
    end else if (rst_fall) begin
      out_q  <= sar_adc_pkg::DATA_RESET;
      data_q <= sar_adc_pkg::DATA_RESET;
    end else begin
      if (pop) out_q <= rf.rd_data;
      data_q <= portion_word(code_result(out_q, i_mode, i_coding_select),
                             i_mode, i_portion_select_hi, i_portion_select_lo);
    end
  end

  // Bus drives in parallel modes whenever both selects and the reset pin are low, also in master style
  assign o_data_out = data_q;
  assign o_data_oe  = (enabled && !serial) ? 18'h3FFFF : 18'h00000;

  // Serial loads: previous result at start, or new result on drain
  assign load_sh = serial && ((!ext_clk && i_read_during_convert_sel && conv_go)
                   || (pop && (ext_clk || !i_read_during_convert_sel)));
  assign half    = i_read_during_convert_sel
                   ? ((bit_cnt_q < 5'(sar_adc_pkg::FAST_BITS)) ? 6'(sar_adc_pkg::FAST_HALF)
                                                              : 6'(sar_adc_pkg::SLOW_HALF))
                   : 6'(sar_adc_pkg::DIV_BASE_HALF) << i_clock_divider_sel;
  assign tick     = run_q && (div_q == half - 6'h01);
  assign ser_done = tick && sclk_q && (bit_cnt_q == 5'(sar_adc_pkg::RES_BITS - 1));
  // External clock counted only while selected
  assign ext_fall = serial && ext_clk && enabled
                    && ((sclk_in_q ^ i_clock_invert) && !(i_serial_clock ^ i_clock_invert))
                    && (bit_cnt_q != 5'(sar_adc_pkg::RES_BITS));

  // Divider enable for the internal serial clock
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      div_q <= 6'h00;
    end else if (!run_q || tick || load_sh) begin
      div_q <= 6'h00;
    end else begin
      div_q <= div_q + 6'h01;
    end
  end

  // Shifter shared by internal and external clocking
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sh_q      <= sar_adc_pkg::DATA_RESET;
      bit_cnt_q <= 5'h00;
      run_q     <= 1'b0;
      sclk_q    <= 1'b0;
    end else if (rst_pin_q || i_reset_pin) begin
      sh_q      <= sar_adc_pkg::DATA_RESET;
      bit_cnt_q <= 5'h00;
      run_q     <= 1'b0;
      sclk_q    <= 1'b0;
    end else if (load_sh) begin
      sh_q      <= code_result(pop ? rf.rd_data : out_q, i_mode, i_coding_select);
      bit_cnt_q <= 5'h00;
      run_q     <= !ext_clk;
      sclk_q    <= 1'b0;
    end else if (tick) begin
      sclk_q <= !sclk_q;
      // Bit moves on the falling edge, stable across the rising one
      if (sclk_q) begin
        sh_q      <= {sh_q[16:0], 1'b0};
        bit_cnt_q <= bit_cnt_q + 5'h01;
        if (ser_done) run_q <= 1'b0;
      end
    end else if (ext_fall) begin
      sh_q      <= {sh_q[16:0], 1'b0};
      bit_cnt_q <= bit_cnt_q + 5'h01;
    end
  end

  // Host clock should be quiet late in busy, so no guard here
  assign o_serial_data_out = sh_q[17];
  assign o_serial_data_oe  = enabled && serial;
  assign o_serial_clock    = sclk_q ^ i_clock_invert;
  assign o_serial_clock_oe = enabled && serial && !ext_clk;
  assign o_frame           = run_q ^ i_frame_invert;
  assign o_frame_oe        = enabled && serial && !ext_clk;

  // Overrun pulse when previous result not fully read
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ovr_q <= 1'b0;
    end else begin
      ovr_q <= conv_end && serial && ext_clk && i_read_during_convert_sel
               && (bit_cnt_q != 5'(sar_adc_pkg::RES_BITS));
    end
  end

  assign o_read_overrun_flag = ovr_q;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_reset_n);

  sequence s_shift_end;
    state_q == sar_adc_pkg::ST_SHIFT && ser_done;
  endsequence

  a_start_begins_conv: assert property (conv_go |=> state_q == sar_adc_pkg::ST_CONV)
    else $error("start edge did not begin a conversion");
  a_conv_not_aborted: assert property (state_q == sar_adc_pkg::ST_CONV && !conv_end
      && !i_reset_pin && !rst_pin_q |=> state_q == sar_adc_pkg::ST_CONV)
    else $error("conversion left early");
  a_pd_waits_conv: assert property (state_q == sar_adc_pkg::ST_CONV
      |-> !o_power_down_active)
    else $error("power-down during conversion");
  a_cfg_pd_pin: assert property (cfg_q == 2'h2 |-> !o_power_down_active)
    else $error("power-down pin not ignored");
  a_low_power_idle: assert property (i_low_power_mode && state_q == sar_adc_pkg::ST_IDLE
      |-> !o_core_power_on)
    else $error("core power kept in low-power idle");
  a_bus_high_z: assert property ((i_cs_n || i_rd_n) |-> o_data_oe == 18'h00000
      && !o_serial_data_oe && !o_serial_clock_oe)
    else $error("outputs driven while deselected");
  a_full_width_bin: assert property (i_mode == sar_adc_pkg::MODE_PAR18 && !rst_fall
      |=> o_data_out == $past(out_q))
    else $error("18-bit word not straight binary");
  a_reset_abort: assert property (rst_rise |=> state_q == sar_adc_pkg::ST_IDLE
      && o_data_oe == 18'h00000)
    else $error("reset edge did not abort");
  a_reset_clear: assert property (rst_fall |=> out_q == 18'h00000 && cfg_q == 2'h0)
    else $error("reset fall did not clear");
  a_busy_till_sent: assert property (s_shift_end |=> !o_busy)
    else $error("busy not released after 18 bits");
  a_overrun_pulse: assert property (conv_end && serial && ext_clk
      && i_read_during_convert_sel && bit_cnt_q != 5'h12
      |=> o_read_overrun_flag ##1 !o_read_overrun_flag)
    else $error("overrun not pulsed once");
endmodule : sar_adc_host_interface

/* File: verilog/sar_adc_pkg.sv */
// Shared constants and types of the converter control block
package sar_adc_pkg;
  localparam int          RES_BITS      = 18;
  localparam int          FIFO_DEPTH    = 32;
  localparam int          CLK_PERIOD_NS = 8;
  // Conversion phase length, rounded up to whole clocks
  localparam int          T_CONV_NS     = 1100;
  localparam int          CONV_CYCLES   = (T_CONV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Serial half periods in clocks
  localparam int          FAST_HALF     = 2;
  localparam int          SLOW_HALF     = 4;
  localparam int          FAST_BITS     = 14;
  localparam int          DIV_BASE_HALF = 2;
  localparam logic [1:0]  MODE_PAR18    = 2'h0;
  localparam logic [1:0]  MODE_PAR16    = 2'h1;
  localparam logic [1:0]  MODE_PAR8     = 2'h2;
  localparam logic [1:0]  MODE_SERIAL   = 2'h3;
  localparam int          CFG_PD_BIT    = 0;
  localparam int          CFG_USE_BIT   = 1;
  localparam logic [1:0]  CFG_RESET     = 2'h0;
  localparam logic [17:0] DATA_RESET    = 18'h00000;
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_CONV  = 4'b0010,
    ST_STORE = 4'b0100,
    ST_SHIFT = 4'b1000
  } conv_state_type;
endpackage : sar_adc_pkg

/* File: verilog/result_fifo_if.sv */
// Valid/ready carrier between the control logic and the result FIFO
`timescale 1ns/10ps
interface result_fifo_if #(parameter int WIDTH = 18);
  logic             wr_valid;
  logic             wr_ready;
  logic [WIDTH-1:0] wr_data;
  logic             rd_valid;
  logic             rd_ready;
  logic [WIDTH-1:0] rd_data;
  modport fifo (input wr_valid, wr_data, rd_ready, output wr_ready, rd_valid, rd_data);
  modport user (output wr_valid, wr_data, rd_ready, input wr_ready, rd_valid, rd_data);
endinterface : result_fifo_if

/* File: verilog/result_fifo.sv */
// Result FIFO with a registered output stage
`timescale 1ns/10ps
module result_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 32
) (
  input  wire logic   i_clk,
  input  wire logic   i_reset_n,
  input  wire logic   i_flush,
  result_fifo_if.fifo f
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wp_q;
  logic [AW:0]      rp_q;
  logic             ov_q;
  logic [WIDTH-1:0] out_q;
  logic             empty;
  logic             full;
  logic             push;
  logic             load;

  // Extra pointer bit tells full from empty
  assign empty      = (wp_q == rp_q);
  assign full       = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
  assign f.wr_ready = !full;
  assign push       = f.wr_valid && !full;
  assign load       = !empty && (!ov_q || f.rd_ready);
  assign f.rd_valid = ov_q;
  assign f.rd_data  = out_q;

  // Storage has no reset, pointers and output register do
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wp_q[AW-1:0]] <= f.wr_data;
    end
  end

  // Pointers
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wp_q <= '0;
      rp_q <= '0;
    end else if (i_flush) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      if (push) wp_q <= wp_q + 1'b1;
      if (load) rp_q <= rp_q + 1'b1;
    end
  end

  // Output register, read data always from a flop
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ov_q  <= 1'b0;
      out_q <= '0;
    end else if (i_flush) begin
      ov_q  <= 1'b0;
    end else if (load) begin
      ov_q  <= 1'b1;
      out_q <= mem[rp_q[AW-1:0]];
    end else if (f.rd_ready) begin
      ov_q  <= 1'b0;
    end
  end
endmodule : result_fifo

/* File: tb/host_serial_model.sv */
// Host reader model: drives or follows the serial clock and gathers result bits
`timescale 1ns/10ps
module host_serial_model (
  input  wire logic        i_clk,
  input  wire logic        i_reset_n,
  input  wire logic        i_go,
  input  wire logic        i_ext,
  input  wire logic        i_sclk,
  input  wire logic        i_inv,
  input  wire logic        i_sdo,
  output logic             o_sclk,
  output logic [17:0]      o_word,
  output logic [4:0]       o_bits
);
  logic prev_q;
  logic run_q;
  logic ph_q;
  // Own clock stands low outside a read, so no stray edges reach the device
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_sclk <= 1'b0;
      o_word <= 18'h00000;
      o_bits <= 5'h00;
      run_q  <= 1'b0;
      ph_q   <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      prev_q <= i_sclk ^ i_inv;
      ph_q   <= ~ph_q;
      if (i_go) begin
        o_bits <= 5'h00;
        run_q  <= i_ext;
      end else if (!i_ext && (i_sclk ^ i_inv) && !prev_q) begin
        o_word <= {o_word[16:0], i_sdo};
        o_bits <= o_bits + 5'h01;
      end else if (run_q && ph_q) begin // Short read, ends well before late busy
        o_sclk <= ~o_sclk;
        if (!o_sclk) begin
          o_word <= {o_word[16:0], i_sdo};
          o_bits <= o_bits + 5'h01;
        end
        run_q <= !(o_sclk && o_bits == 5'h12);
      end
    end
  end
endmodule : host_serial_model

/* File: tb/sar_adc_host_interface_tb_top.sv */
// Self-checking bench of the converter control and host readout
`timescale 1ns/10ps
module sar_adc_host_interface_tb_top;
  typedef struct {int s; logic [17:0] e;} note_type;
  logic        clk, rst_n, rpin, cnv_n, pd, lp, cfg_wr, cs_n, rd_n, cod, plo, phi, ext, read_during_convert_sel;
  logic        cinv, finv, go, ovr_seen, busy, sdo, sdo_oe, sclk, sclk_oe, frm, frm_oe;
  logic        ovr, pda, core, hclk;
  logic [1:0]  cfg_d, mode, div, cfg;
  logic [17:0] samp, dout, doe, word, c;
  logic [17:0] s [0:7];
  logic [3:0]  tbl [0:4];
  logic [4:0]  bits;
  int          n_fail, checks_done, blen;
  note_type    q[$];

  sar_adc_host_interface u_sar_adc_host_interface (
    .i_clk(clk), .i_reset_n(rst_n), .i_reset_pin(rpin), .i_conversion_start_n(cnv_n),
    .i_power_down_pin(pd), .i_low_power_mode(lp), .i_cfg_write(cfg_wr), .i_cfg_data(cfg_d),
    .i_cs_n(cs_n), .i_rd_n(rd_n), .i_mode(mode), .i_coding_select(cod),
    .i_portion_select_lo(plo), .i_portion_select_hi(phi), .i_clock_source_select(ext),
    .i_read_during_convert_sel(read_during_convert_sel), .i_clock_divider_sel(div), .i_clock_invert(cinv),
    .i_frame_invert(finv), .i_serial_clock(hclk), .i_sample_data(samp), .o_busy(busy),
    .o_data_out(dout), .o_data_oe(doe), .o_serial_data_out(sdo), .o_serial_data_oe(sdo_oe),
    .o_serial_clock(sclk), .o_serial_clock_oe(sclk_oe), .o_frame(frm), .o_frame_oe(frm_oe),
    .o_read_overrun_flag(ovr), .o_power_down_active(pda), .o_core_power_on(core),
    .o_config(cfg));
  host_serial_model u_host_serial_model (
    .i_clk(clk), .i_reset_n(rst_n), .i_go(go), .i_ext(ext), .i_sclk(sclk), .i_inv(cinv),
    .i_sdo(sdo), .o_sclk(hclk), .o_word(word), .o_bits(bits));

  // 125 MHz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // One-cycle overrun pulse is easy to miss from the driver, so latch it
  // Sampled mid-cycle, away from the edge that launches the flag
  always @(negedge clk) begin
    if (ovr === 1'b1) ovr_seen <= 1'b1;
  end

  function automatic logic [17:0] seen(input int k);
    case (k)
      0: seen = dout;
      1: seen = 18'(blen);
      2: seen = word;
      3: seen = {16'h0000, cfg};
      4: seen = {17'h00000, busy};
      5: seen = doe;
      6: seen = {17'h00000, pda};
      7: seen = {17'h00000, ovr_seen};
      8: seen = {17'h00000, core};
      9: seen = {17'h00000, frm};
      11: seen = {15'h0000, sdo_oe, sclk_oe, frm_oe};
      default: seen = {13'h0000, bits};
    endcase
  endfunction : seen
  // Narrow parallel views, table key is {mode, hi select, lo select}
  function automatic logic [17:0] part(input logic [17:0] v, input logic [3:0] t);
    case (t)
      4'h4: part = {2'h0, v[17:2]};
      4'h5: part = {2'h0, v[1:0], 14'h0000};
      4'h8: part = {10'h000, v[17:10]};
      4'h9: part = {10'h000, v[9:2]};
      default: part = {10'h000, v[1:0], 6'h00};
    endcase
  endfunction : part

  task automatic check(input logic [17:0] got, input logic [17:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic note(input int k, input logic [17:0] e);
    q.push_back('{k, e});
  endtask : note
  task automatic close_out();
    #1;
    if (n_fail == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : close_out
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick
  task automatic pulse_go();
    go = 1'b1;
    tick(1);
    go = 1'b0;
  endtask : pulse_go
  task automatic cfg_write(input logic [1:0] v);
    cfg_d  = v;
    cfg_wr = 1'b1;
    tick(1);
    cfg_wr = 1'b0;
    tick(2);
  endtask : cfg_write
  // Start, then a second start edge and optional power-down while running
  task automatic convert(input logic [17:0] v, input logic pd_mid);
    int i;
    samp  = v;
    cnv_n = 1'b0;
    tick(1);
    cnv_n = 1'b1;
    blen  = 0;
    for (i = 0; i < 4 && busy !== 1'b1; i++) tick(1);
    while (busy === 1'b1 && blen < 3000) begin
      blen++;
      cnv_n = (blen != 20);
      if (blen == 20) pd = pd_mid;
      if (blen == 30) note(8, 18'h00001);
      tick(1);
    end
    cnv_n = 1'b1;
    if (blen == 0 || blen == 3000) begin
      n_fail++;
      close_out();
    end
  endtask : convert

  // Compares each noted result against what the outputs show
  initial begin : watch
    note_type x;
    forever begin
      wait (q.size() != 0);
      x = q.pop_front();
      check(seen(x.s), x.e);
    end
  end

  initial begin
    int k;
    void'($urandom(32'hE4D5871F));
    for (k = 0; k < 8; k++) s[k] = 18'($urandom);
    tbl = '{4'h4, 4'h5, 4'h8, 4'h9, 4'hA};
    {rst_n, rpin, pd, lp, cfg_wr, cod, plo, phi, ext, read_during_convert_sel, cinv, finv, go} = 13'h0000;
    {cnv_n, cs_n, rd_n, ovr_seen} = 4'hE;
    {cfg_d, mode, div} = 6'h00;
    samp = 18'h00000;
    tick(12);
    rst_n = 1'b1;
    tick(2);
    note(3, 18'h00000);
    note(5, 18'h00000);
    // Start with selects high, full width read afterwards, coding ignored
    convert(s[0], 1'b0);
    note(1, 18'h0008B);
    cs_n = 1'b0; // Read during acquisition
    rd_n = 1'b0;
    tick(4);
    note(5, 18'h3FFFF);
    note(0, s[0]);
    c = {~s[0][17], s[0][16:0]};
    for (k = 0; k < 5; k++) begin
      {mode, phi, plo} = tbl[k];
      tick(2);
      note(0, part(c, tbl[k]));
    end
    {cod, mode, phi, plo} = 5'h14;
    tick(2);
    note(0, {2'h0, s[0][17:2]});
    rd_n = 1'b1;
    tick(1);
    note(5, 18'h00000);
    // Power-down raised mid-run does not cut the conversion short
    lp = 1'b1;
    convert(s[1], 1'b1);
    note(1, 18'h0008B);
    tick(1);
    note(6, 18'h00001);
    cnv_n = 1'b0;
    tick(1);
    cnv_n = 1'b1;
    tick(3);
    note(4, 18'h00000);
    pd = 1'b0;
    tick(2);
    note(8, 18'h00000);
    // Configuration only taken in serial mode, then overrides the pin
    mode = 2'h0;
    cfg_write(2'h3);
    note(3, 18'h00000);
    {mode, ext, rd_n, pd} = 5'h1D;
    cfg_write(2'h2);
    note(3, 18'h00002);
    note(11, 18'h00004);
    convert(s[2], 1'b1);
    note(1, 18'h0008B);
    note(5, 18'h00000);
    tick(2); // New result must reach the shifter before the host clocks
    pulse_go();
    for (k = 0; k < 200 && bits !== 5'h12; k++) tick(1);
    if (k == 200) begin
      n_fail++;
      close_out();
    end
    note(2, s[2]);
    pd = 1'b0;
    cfg_write(2'h3);
    note(6, 18'h00001);
    cfg_write(2'h2);
    // External read of the previous result during the next conversion
    read_during_convert_sel = 1'b1;
    convert(s[3], 1'b0);
    ovr_seen = 1'b0;
    fork
      convert(s[4], 1'b0);
      begin
        tick(2);
        pulse_go();
      end
    join
    tick(3);
    note(2, s[3]);
    note(7, 18'h00000);
    convert(s[5], 1'b0);
    tick(3);
    note(7, 18'h00001);
    // Internal clock, read after conversion, random divider and inversions
    {ext, read_during_convert_sel} = 2'h0;
    div  = 2'($urandom);
    cinv = 1'($urandom);
    finv = 1'($urandom);
    tick(3);
    note(9, {17'h00000, finv});
    note(11, 18'h00007);
    pulse_go();
    convert(s[6], 1'b0);
    note(10, 18'h00012);
    note(2, s[6]);
    // Internal read-during: each conversion shifts out the one before it
    read_during_convert_sel = 1'b1;
    convert(s[7], 1'b0);
    pulse_go();
    convert(s[1], 1'b0);
    note(1, 18'h0008B);
    note(10, 18'h00012);
    note(2, s[7]);
    // Reset pin in mid conversion, then clear on its release
    mode = 2'h0;
    cnv_n = 1'b0;
    tick(1);
    cnv_n = 1'b1;
    tick(10);
    rpin = 1'b1;
    tick(2);
    note(4, 18'h00000);
    note(5, 18'h00000);
    rpin = 1'b0;
    tick(3);
    note(0, 18'h00000);
    note(3, 18'h00000);
    tick(2);
    close_out();
  end
endmodule : sar_adc_host_interface_tb_top
